/* ccd_cfg.svh */
/*
  Offsets, field positions, reset values and timing counts for the
  call/clear/decrement execution block. Included by the core and the bench;
  assumes a 12-bit byte address window on an AHB-Lite bus.
*/
`ifndef CCD_CFG_SVH
`define CCD_CFG_SVH

// Register byte offsets.
`define CCD_OFF_OP 12'h000
`define CCD_OFF_ACC 12'h004
`define CCD_OFF_PC 12'h008
`define CCD_OFF_LATCH 12'h00c
`define CCD_OFF_STAT 12'h010
`define CCD_OFF_STACK 12'h014
`define CCD_OFF_WDOG 12'h018
// File register f sits at 0x200 + 4*f; bits 11:9 select the region.
`define CCD_FILE_REGION 3'h1

// Operation register fields.
`define CCD_OP_CODE_HI 2
`define CCD_OP_CODE_LO 0
`define CCD_OP_DEST 3
`define CCD_OP_FILE_HI 10
`define CCD_OP_FILE_LO 4
`define CCD_OP_IMM_HI 26
`define CCD_OP_IMM_LO 16

// Status register fields.
`define CCD_ST_BUSY 0
`define CCD_ST_ZERO 2
`define CCD_ST_PD 3
`define CCD_ST_TO 4

// Page bits of the upper_pc_latch copied into PC bits 12:11.
`define CCD_LATCH_PAGE_HI 4
`define CCD_LATCH_PAGE_LO 3

// Reset values.
`define CCD_PC_RST 13'h0000
`define CCD_ACC_RST 8'h00
`define CCD_LATCH_RST 8'h00
`define CCD_TO_RST 1'b1
`define CCD_PD_RST 1'b1

// Clocks per instruction cycle at 125 MHz.
`define CCD_TICK_DIV 4

`endif

/* ccd_pkg.sv */
/*
  Types for the call/clear/decrement execution block: operation codes,
  execution phases, the decoded operation and the whole core state.
  Assumes ccd_cfg.svh is on the include path.
*/
package ccd_pkg;

  // Operation codes as written into the operation register.
  typedef enum logic [2:0] {
    OP_CALL, OP_KICK, OP_FZERO, OP_AZERO, OP_INV, OP_DEC, OP_DSKIP, OP_NONE
  } ccd_op_t;

  // Execution phase of the issued operation.
  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_SECOND} ccd_ph_t;

  // One decoded operation.
  typedef struct packed {
    ccd_op_t op;
    logic dest;
    logic [6:0] file;
    logic [10:0] imm;
  } ccd_instr_t;

  // Entire state of the core, registered as one word.
  typedef struct packed {
    logic hready;
    logic hresp;
    logic [31:0] hrdata;
    logic dph;
    logic dwr;
    logic [11:0] daddr;
    logic [7:0] tdiv;
    ccd_ph_t ph;
    ccd_instr_t ins;
    logic [7:0] acc;
    logic [12:0] pc;
    logic [7:0] latch;
    logic z;
    logic pd;
    logic to;
    logic [7:0][12:0] stack;
    logic [2:0] sp;
    logic [7:0] pre;
    logic [7:0] wdog;
    logic [127:0][7:0] file;
  } ccd_state_t;

endpackage

/* ccd_core.sv */
/*
  Execution core for the subroutine call, watchdog clear, clear, complement,
  decrement and decrement-with-skip operations, with its register file,
  accumulator, program counter, eight-entry return stack and watchdog.
  Assumes a single AHB-Lite master whose hready is this slave's hreadyout.
*/
// How it works
// - Call loads the 11-bit immediate into PC bits 10:0.
// - Call fills PC bits 12:11 from latch bits 4:3.
// - Call first pushes PC plus one; it becomes the stack head.
// - Call takes two instruction cycles and alters no status flag.
// - Watchdog kick clears the watchdog counter and its prescaler.
// - Watchdog kick sets both timeout and powerdown flags.
// - File zero writes zero to the addressed register and sets zero flag.
// - Accumulator zero clears the accumulator and sets zero flag.
// - Invert stores the complement by destination bit; updates zero flag.
// - Decrement stores register minus one by destination; updates zero.
// - Decrement-skip routes like decrement but changes no status flag.
// - A zero decrement-skip result replaces the next op by an idle cycle.
`timescale 1ns/10ps
`include "ccd_cfg.svh"

module ccd_core import ccd_pkg::*; #(
  parameter int TICK_DIV = `CCD_TICK_DIV
) (
  input wire logic hclk, // 125 MHz bus and core clock.
  input wire logic hresetn, // Asynchronous reset, active low.
  input wire logic hsel, // Slave select.
  input wire logic [31:0] haddr, // Byte address.
  input wire logic [1:0] htrans, // Transfer type.
  input wire logic hwrite, // Write when high.
  input wire logic [2:0] hsize, // Transfer size, word only.
  input wire logic [31:0] hwdata, // Write data.
  input wire logic hready, // Bus ready.
  output logic hreadyout, // Slave ready.
  output logic hresp, // Always OKAY.
  output logic [31:0] hrdata // Read data.
);

  // The divider counter is eight bits wide.
  if (TICK_DIV < 1 || TICK_DIV > 256) begin : g_chk
    $error("TICK_DIV must lie between 1 and 256");
  end

  localparam logic [7:0] TICK_LAST = 8'(TICK_DIV - 1);

  ccd_state_t r_reg;
  ccd_state_t r_next;
  logic tick;
  logic exec;
  logic [7:0] fv;
  logic [12:0] stack_head;

  // True when a byte is zero; used for the invert and decrement zero flag and the skip test.
  function automatic logic is_null(input logic [7:0] v);
    return v == 8'h00;
  endfunction

  // Register read multiplexer; unmapped addresses read as zero.
  function automatic logic [31:0] rd(input ccd_state_t s,
                                     input logic [11:0] a);
    logic [31:0] d;
    d = 32'h0000_0000;
    if (a[11:9] == `CCD_FILE_REGION) begin
      d[7:0] = s.file[a[8:2]];
    end else begin
      case (a)
        `CCD_OFF_OP: begin
          d[`CCD_OP_CODE_HI:`CCD_OP_CODE_LO] = s.ins.op;
          d[`CCD_OP_DEST] = s.ins.dest;
          d[`CCD_OP_FILE_HI:`CCD_OP_FILE_LO] = s.ins.file;
          d[`CCD_OP_IMM_HI:`CCD_OP_IMM_LO] = s.ins.imm;
        end
        `CCD_OFF_ACC: d[7:0] = s.acc;
        `CCD_OFF_PC: d[12:0] = s.pc;
        `CCD_OFF_LATCH: d[7:0] = s.latch;
        `CCD_OFF_STAT: begin
          d[`CCD_ST_BUSY] = s.ph != ST_IDLE;
          d[`CCD_ST_ZERO] = s.z;
          d[`CCD_ST_PD] = s.pd;
          d[`CCD_ST_TO] = s.to;
        end
        `CCD_OFF_STACK: begin
          d[12:0] = s.stack[3'(s.sp - 3'h1)];
          d[18:16] = s.sp;
        end
        `CCD_OFF_WDOG: begin
          d[7:0] = s.wdog;
          d[15:8] = s.pre;
        end
        default: d = 32'h0000_0000;
      endcase
    end
    return d;
  endfunction

  // Helper views shared by the next-state logic and the checks.
  assign tick = r_reg.tdiv == TICK_LAST;
  assign exec = tick && r_reg.ph == ST_WAIT;
  assign fv = r_reg.file[r_reg.ins.file];
  assign stack_head = r_reg.stack[3'(r_reg.sp - 3'h1)];

  // Next state: bus slave first, then watchdog, then execution, so that
  // hardware updates land last and win over a software write that cycle.
  always_comb begin
    logic [7:0] res;
    res = 8'h00;
    r_next = r_reg;
    r_next.tdiv = tick ? 8'h00 : 8'(r_reg.tdiv + 8'h01);

    // Data phase. An operation write while one is still running is held
    // with wait states rather than dropped, so software never loses one.
    if (r_reg.dph) begin
      if (!(r_reg.dwr && r_reg.daddr == `CCD_OFF_OP &&
            r_reg.ph != ST_IDLE)) begin
        r_next.dph = 1'b0;
        r_next.hready = 1'b1;
        if (!r_reg.dwr) begin
          r_next.hrdata = rd(r_reg, r_reg.daddr);
        end else if (r_reg.daddr[11:9] == `CCD_FILE_REGION) begin
          r_next.file[r_reg.daddr[8:2]] = hwdata[7:0];
        end else begin
          case (r_reg.daddr)
            `CCD_OFF_OP: begin
              r_next.ins.op =
                ccd_op_t'(hwdata[`CCD_OP_CODE_HI:`CCD_OP_CODE_LO]);
              r_next.ins.dest = hwdata[`CCD_OP_DEST];
              r_next.ins.file = hwdata[`CCD_OP_FILE_HI:`CCD_OP_FILE_LO];
              r_next.ins.imm = hwdata[`CCD_OP_IMM_HI:`CCD_OP_IMM_LO];
              r_next.ph = ST_WAIT;
            end
            `CCD_OFF_ACC: r_next.acc = hwdata[7:0];
            `CCD_OFF_PC: r_next.pc = hwdata[12:0];
            `CCD_OFF_LATCH: r_next.latch = hwdata[7:0];
            `CCD_OFF_STAT: begin
              r_next.z = hwdata[`CCD_ST_ZERO];
              r_next.pd = hwdata[`CCD_ST_PD];
              r_next.to = hwdata[`CCD_ST_TO];
            end
            default: r_next.dph = 1'b0;
          endcase
        end
      end
    end else if (hsel && htrans[1] && hready) begin
      // Address phase: capture it and answer after one wait state.
      r_next.dph = 1'b1;
      r_next.dwr = hwrite;
      r_next.daddr = haddr[11:0];
      r_next.hready = 1'b0;
    end

    // Watchdog runs one prescaler step per instruction cycle and saturates.
    if (tick) begin
      r_next.pre = 8'(r_reg.pre + 8'h01);
      if (r_reg.pre == 8'hff && r_reg.wdog != 8'hff) begin
        r_next.wdog = 8'(r_reg.wdog + 8'h01);
      end
    end

    // Execution, one step per instruction cycle.
    if (tick) begin
      case (r_reg.ph)
        ST_WAIT: begin
          r_next.ph = ST_IDLE;
          r_next.pc = 13'(r_reg.pc + 13'h0001);
          case (r_reg.ins.op)
            OP_CALL: begin
              r_next.stack[r_reg.sp] = 13'(r_reg.pc + 13'h0001);
              r_next.sp = 3'(r_reg.sp + 3'h1);
              r_next.pc[10:0] = r_reg.ins.imm;
              r_next.pc[12:11] = r_reg.latch[`CCD_LATCH_PAGE_HI:
                                             `CCD_LATCH_PAGE_LO];
              r_next.ph = ST_SECOND;
            end
            OP_KICK: begin
              r_next.pre = 8'h00;
              r_next.wdog = 8'h00;
              r_next.to = 1'b1;
              r_next.pd = 1'b1;
            end
            OP_FZERO: begin
              r_next.file[r_reg.ins.file] = 8'h00;
              r_next.z = 1'b1;
            end
            OP_AZERO: begin
              r_next.acc = 8'h00;
              r_next.z = 1'b1;
            end
            OP_INV, OP_DEC, OP_DSKIP: begin
              res = (r_reg.ins.op == OP_INV) ? ~fv : 8'(fv - 8'h01);
              if (r_reg.ins.dest) begin
                r_next.file[r_reg.ins.file] = res;
              end else begin
                r_next.acc = res;
              end
              if (r_reg.ins.op != OP_DSKIP) begin
                r_next.z = is_null(res);
              end else begin
                // The zero flag keeps its value here, even over a bus write; to and pd are left as set.
                r_next.z = r_reg.z;
                if (is_null(res)) begin
                  r_next.pc = 13'(r_reg.pc + 13'h0002);
                  r_next.ph = ST_SECOND;
                end
              end
            end
            default: r_next.ph = ST_IDLE;
          endcase
        end
        ST_SECOND: r_next.ph = ST_IDLE;
        default: begin
          // Idle: leave ph alone so an operation written this cycle starts.
        end
      endcase
    end
  end

  // State register; every output is a field of it.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r_reg <= '0;
      r_reg.hready <= 1'b1;
      r_reg.ph <= ST_IDLE;
      r_reg.ins.op <= OP_NONE;
      r_reg.pc <= `CCD_PC_RST;
      r_reg.acc <= `CCD_ACC_RST;
      r_reg.latch <= `CCD_LATCH_RST;
      r_reg.to <= `CCD_TO_RST;
      r_reg.pd <= `CCD_PD_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  assign hreadyout = r_reg.hready;
  assign hresp = r_reg.hresp;
  assign hrdata = r_reg.hrdata;

  // Every check below samples on the core clock and rests during reset.
  default clocking core_cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // A call puts its immediate into the low program counter bits.
  AST_CALL_LOW: assert property (
    exec && r_reg.ins.op == OP_CALL |=>
      r_reg.pc[10:0] == $past(r_reg.ins.imm))
    else $error("call low pc wrong");

  // The page bits come from the latch, not from the old counter.
  AST_CALL_PAGE: assert property (
    exec && r_reg.ins.op == OP_CALL |=>
      r_reg.pc[12:11] ==
      $past(r_reg.latch[`CCD_LATCH_PAGE_HI:`CCD_LATCH_PAGE_LO]))
    else $error("call page wrong");

  // The return address is the old counter plus one, now on top.
  AST_CALL_PUSH: assert property (
    exec && r_reg.ins.op == OP_CALL |=>
      stack_head == 13'($past(r_reg.pc) + 13'h0001))
    else $error("bad return");

  // A call enters its second cycle with the flags untouched.
  AST_CALL_TWO: assert property (
    exec && r_reg.ins.op == OP_CALL && !r_reg.dph |=>
      r_reg.ph == ST_SECOND && $stable({r_reg.z, r_reg.to, r_reg.pd}))
    else $error("call length or flags wrong");

  // The extra cycle ends exactly at the next divider tick; the divider
  // is the counter, so no long repetition is needed to time it.
  AST_SECOND_LEN: assert property (
    r_reg.ph == ST_SECOND |=> (r_reg.ph == ST_IDLE) == $past(tick))
    else $error("second cycle length wrong");

  // A kick restarts both the watchdog counter and its prescaler.
  AST_KICK_CLR: assert property (
    exec && r_reg.ins.op == OP_KICK |=>
      r_reg.wdog == 8'h00 && r_reg.pre == 8'h00)
    else $error("watchdog not cleared");

  // A kick sets both the timeout and the powerdown flag.
  AST_KICK_FLAGS: assert property (
    exec && r_reg.ins.op == OP_KICK |=> r_reg.to && r_reg.pd)
    else $error("kick flags not set");

  // File zero clears the addressed register and sets the zero flag.
  AST_FZERO: assert property (
    exec && r_reg.ins.op == OP_FZERO |=>
      r_reg.z && r_reg.file[$past(r_reg.ins.file)] == 8'h00)
    else $error("file not cleared");

  // Accumulator zero clears the accumulator and sets the zero flag.
  AST_AZERO: assert property (
    exec && r_reg.ins.op == OP_AZERO |=> r_reg.z && r_reg.acc == 8'h00)
    else $error("accumulator not cleared");

  // Complement to either destination, zero flag from the result.
  AST_INV_ACC: assert property (
    exec && r_reg.ins.op == OP_INV && !r_reg.ins.dest |=>
      r_reg.acc == ~$past(fv) && r_reg.z == (r_reg.acc == 8'h00))
    else $error("complement wrong");

  AST_INV_FILE: assert property (
    exec && r_reg.ins.op == OP_INV && r_reg.ins.dest |=>
      r_reg.file[$past(r_reg.ins.file)] == ~$past(fv) &&
      r_reg.z == ($past(fv) == 8'hff))
    else $error("complement to file wrong");

  // Decrement to either destination, zero flag from the result.
  AST_DEC_ACC: assert property (
    exec && r_reg.ins.op == OP_DEC && !r_reg.ins.dest |=>
      r_reg.acc == 8'($past(fv) - 8'h01) && r_reg.z == (r_reg.acc == 8'h00))
    else $error("decrement wrong");

  AST_DEC_FILE: assert property (
    exec && r_reg.ins.op == OP_DEC && r_reg.ins.dest |=>
      r_reg.file[$past(r_reg.ins.file)] == 8'($past(fv) - 8'h01) &&
      r_reg.z == ($past(fv) == 8'h01))
    else $error("decrement to file wrong");

  // The skip form leaves every status flag alone.
  AST_DSKIP_FLAGS: assert property (
    exec && r_reg.ins.op == OP_DSKIP && !r_reg.dph |=>
      $stable({r_reg.z, r_reg.to, r_reg.pd}))
    else $error("skip altered a flag");

  // A zero result skips: the counter moves by two, an idle cycle runs.
  AST_DSKIP_SKIP: assert property (
    exec && r_reg.ins.op == OP_DSKIP && fv == 8'h01 |=>
      r_reg.ph == ST_SECOND && r_reg.pc == 13'($past(r_reg.pc) + 13'h0002))
    else $error("skip not taken");

  // Without a zero result the skip form just moves on by one.
  AST_DSKIP_STAY: assert property (
    exec && r_reg.ins.op == OP_DSKIP && fv != 8'h01 |=>
      r_reg.pc == 13'($past(r_reg.pc) + 13'h0001))
    else $error("skip taken wrongly");

  // Everything else is done within one instruction cycle.
  AST_ONE_CYCLE: assert property (
    exec && r_reg.ins.op != OP_CALL &&
      !(r_reg.ins.op == OP_DSKIP && fv == 8'h01) |=> r_reg.ph == ST_IDLE)
    else $error("single cycle op took longer");

endmodule // ccd_core

/* tb_top.sv */
/*
  Self-checking bench for the call/clear/decrement execution core.
  Assumes ccd_pkg and ccd_core are compiled first, with ccd_cfg.svh on the
  include path, and a single AHB-Lite master whose hready is hreadyout.
*/
`timescale 1ns/10ps
`include "ccd_cfg.svh"

module tb_top;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata;
  int n_fail, samples_checked, cycles, seed, i;
  logic [12:0] pc0;
  logic [10:0] k;
  logic [7:0] lt, v, a0, res, st;
  logic [6:0] f;
  logic [2:0] c;
  logic d;

  // A short divider keeps each instruction cycle to two clocks.
  ccd_core #(.TICK_DIV(2)) i_ccd_core (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));

  // Free-running 125 MHz clock.
  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end

  // Hang guard: a run that outlives its budget counts as a mismatch.
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 60000) begin
      n_fail++;
      give_verdict();
    end
  end

  task give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One single AHB-Lite transfer; signals move only after rising edges.
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] wd,
            output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {20'h0, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task wr(input logic [11:0] a, input logic [31:0] wd);
    logic [31:0] x;
    xfer(1'b1, a, wd, x);
  endtask

  // Read a register and compare the masked bits with the expectation.
  task rc(input string nm, input logic [11:0] a, input logic [31:0] m,
          input logic [31:0] e);
    logic [31:0] x;
    xfer(1'b0, a, 32'h0, x);
    chk(nm, e & m, x & m);
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask

  // Issue an operation, then poll busy under a bounded count.
  task exec(input logic [31:0] w);
    int n;
    logic [31:0] x;
    n = 0;
    wr(`CCD_OFF_OP, w);
    do begin
      xfer(1'b0, `CCD_OFF_STAT, 32'h0, x);
      n++;
    end while (x[`CCD_ST_BUSY] !== 1'b0 && n < 50);
    chk("busy", 32'h0, {31'h0, x[`CCD_ST_BUSY]});
  endtask

  function automatic logic [31:0] opw(input logic [2:0] cd, input logic ds,
      input logic [6:0] fi, input logic [10:0] im);
    opw = {5'h0, im, 5'h0, fi, ds, cd};
  endfunction

  function automatic logic [11:0] fa(input logic [6:0] fi);
    fa = {3'h1, fi, 2'b00};
  endfunction

  // Main sequence: reset, then each operation, with corner and random data for call, invert, decrement and decrement-skip.
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    htrans = 2'b00;
    haddr = 32'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    n_fail = 0;
    samples_checked = 0;
    cycles = 0;
    seed = 68;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    rc("pc_rst", `CCD_OFF_PC, 32'h1fff, 32'h0);
    rc("stat_rst", `CCD_OFF_STAT, 32'h1d, 32'h18);
    rc("unmapped", 12'h100, 32'hffffffff, 32'h0);
    // Calls: top immediate and page first, then random ones.
    for (i = 0; i < 4; i++) begin
      lt = (i == 0) ? 8'h18 : 8'($random(seed));
      k = (i == 0) ? 11'h7ff : 11'($random(seed));
      pc0 = 13'($random(seed));
      st = 8'($random(seed)) & 8'h1c;
      wr(`CCD_OFF_LATCH, {24'h0, lt});
      wr(`CCD_OFF_PC, {19'h0, pc0});
      wr(`CCD_OFF_STAT, {24'h0, st});
      exec(opw(3'h0, 1'b0, 7'h0, k));
      rc("call_pc", `CCD_OFF_PC, 32'h1fff, {19'h0, lt[4:3], k});
      rc("call_head", `CCD_OFF_STACK, 32'h1fff, {19'h0, pc0 + 13'h1});
      rc("call_flags", `CCD_OFF_STAT, 32'h1c, {24'h0, st});
    end
    // Let the watchdog counter advance past zero before the kick.
    wr(`CCD_OFF_STAT, 32'h0);
    repeat (1200) @(posedge hclk);
    exec(opw(3'h1, 1'b0, 7'h0, 11'h0));
    rc("wdog_count", `CCD_OFF_WDOG, 32'hc0ff, 32'h0);
    rc("kick_flags", `CCD_OFF_STAT, 32'h18, 32'h18);
    // Clears: nonzero contents and a cleared zero flag beforehand.
    f = 7'($random(seed));
    wr(fa(f), {24'h0, 8'($random(seed)) | 8'h01});
    wr(`CCD_OFF_ACC, 32'h5a);
    wr(`CCD_OFF_STAT, 32'h0);
    exec(opw(3'h2, 1'b1, f, 11'h0));
    rc("fzero", fa(f), 32'hff, 32'h0);
    rc("fzero_z", `CCD_OFF_STAT, 32'h4, 32'h4);
    wr(`CCD_OFF_STAT, 32'h0);
    exec(opw(3'h3, 1'b0, 7'h0, 11'h0));
    rc("azero", `CCD_OFF_ACC, 32'hff, 32'h0);
    rc("azero_z", `CCD_OFF_STAT, 32'h4, 32'h4);
    // The spare code leaves the accumulator alone but still advances the counter by one.
    wr(`CCD_OFF_ACC, 32'h3c);
    wr(`CCD_OFF_PC, 32'h1fff);
    exec(opw(3'h7, 1'b0, 7'h0, 11'h0));
    rc("none_acc", `CCD_OFF_ACC, 32'hff, 32'h3c);
    rc("none_pc", `CCD_OFF_PC, 32'h1fff, 32'h0);
    // Invert, decrement and decrement-skip over both destinations.
    for (i = 0; i < 16; i++) begin
      c = (i < 12) ? ((i % 2 == 1) ? 3'h5 : 3'h4) : 3'h6;
      d = i[1];
      v = 8'($random(seed));
      if (i < 4 || i == 12 || i == 13) v = (c == 3'h4) ? 8'hff : 8'h01;
      if (c == 3'h6 && i > 13 && v == 8'h01) v = 8'h02;
      f = 7'($random(seed));
      a0 = 8'($random(seed));
      pc0 = 13'($random(seed));
      st = 8'($random(seed)) & 8'h1c;
      res = (c == 3'h4) ? ~v : v - 8'h01;
      wr(fa(f), {24'h0, v});
      wr(`CCD_OFF_ACC, {24'h0, a0});
      wr(`CCD_OFF_PC, {19'h0, pc0});
      wr(`CCD_OFF_STAT, {24'h0, st});
      exec(opw(c, d, f, 11'h0));
      rc("dst_file", fa(f), 32'hff, {24'h0, d ? res : v});
      rc("dst_acc", `CCD_OFF_ACC, 32'hff,
         {24'h0, d ? a0 : res});
      if (c == 3'h6) begin
        rc("skip_flags", `CCD_OFF_STAT, 32'h1c, {24'h0, st});
        rc("skip_pc", `CCD_OFF_PC, 32'h1fff,
           {19'h0, pc0 + ((res == 8'h0) ? 13'h2 : 13'h1)});
      end else begin
        rc("op_z", `CCD_OFF_STAT, 32'h4,
           {29'h0, res == 8'h0, 2'b00});
        rc("op_pc", `CCD_OFF_PC, 32'h1fff, {19'h0, pc0 + 13'h1});
      end
    end
    give_verdict();
  end
endmodule // tb_top
